/* common/irq_sel_pkg.sv */
// Constants shared by the interrupt enable and source-select block.
// Assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses.
package irq_sel_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IE_INDEX   = 8'ha8;
  localparam logic [7:0]  SEL_INDEX  = 8'hba;
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] IE_ADDR    = {2'b00, IE_INDEX, 2'b00};
  localparam logic [11:0] SEL_ADDR   = {2'b00, SEL_INDEX, 2'b00};

  // Enable register fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_SERIAL = 4;
  localparam int IE_T1     = 3;
  localparam int IE_X1     = 2;
  localparam int IE_T0     = 1;
  localparam int IE_X0     = 0;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IE_WMASK = 8'h9f;

  // Select register fields
  localparam int SEL_CD_POL  = 7;
  localparam int SEL_CD_FLAG = 5;
  localparam int SEL_RX_FLAG = 4;
  localparam int SEL_OE_POL  = 3;
  localparam int SEL_OE_EN   = 2;
  localparam int SEL_CD_EN   = 1;
  localparam int SEL_RX_EN   = 0;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] SEL_WMASK = 8'h8f;

  // Request vector towards the core
  localparam int NUM_SRC    = 7;
  localparam int SRC_EXT0   = 0;
  localparam int SRC_TMR0   = 1;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_TMR1   = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_CARD   = 5;
  localparam int SRC_RX     = 6;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Word-aligned address match
  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] target);
    return addr[ADDR_W-1:2] == target[ADDR_W-1:2];
  endfunction

endpackage

/* logic/event_flag.sv */
// Sticky flag: hardware sets it, software clears it.
// Assumes set and clear are synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module event_flag (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t r;
  flag_state_t next_r;

  // Set beats clear so an event in the clearing cycle is kept
  always_comb begin
    next_r      = r;
    next_r.flag = set_i | (r.flag & ~clr_i);
  end

  // Frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign flag_o = r.flag;

endmodule
`default_nettype wire

/* logic/axil_reg_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner decodes addresses and returns read data combinationally.
`timescale 1ns/10ps
`default_nettype none
module axil_reg_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  output logic                   wr_en_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [31:0]            wr_data_o,
  output logic [3:0]             wr_strb_o,
  input  wire logic              wr_ok_i,
  input  wire logic [31:0]       rd_data_i,
  input  wire logic              rd_ok_i
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              have_aw;
    logic              have_w;
    logic              bvalid;
    logic [1:0]        bresp;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } slv_state_t;

  slv_state_t r;
  slv_state_t next_r;
  logic       commit;

  // Address and data may arrive in either order; commit once both are held
  always_comb begin
    next_r = r;
    commit = r.have_aw & r.have_w & ~r.bvalid;
    if (awvalid_i && r.awready) begin
      next_r.have_aw = 1'b1;
      next_r.awaddr  = awaddr_i;
    end
    if (wvalid_i && r.wready) begin
      next_r.have_w = 1'b1;
      next_r.wdata  = wdata_i;
      next_r.wstrb  = wstrb_i;
    end
    if (commit) begin
      next_r.have_aw = 1'b0;
      next_r.have_w  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = wr_ok_i ? irq_sel_pkg::RESP_OKAY : irq_sel_pkg::RESP_SLVERR;
    end
    if (r.bvalid && bready_i) begin
      next_r.bvalid = 1'b0;
    end
    // Readies stay low until the response is taken
    next_r.awready = ~next_r.have_aw & ~next_r.bvalid;
    next_r.wready  = ~next_r.have_w & ~next_r.bvalid;
    // Reads have no side effects, so data is sampled at the handshake
    if (arvalid_i && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_data_i;
      next_r.rresp  = rd_ok_i ? irq_sel_pkg::RESP_OKAY : irq_sel_pkg::RESP_SLVERR;
    end
    if (r.rvalid && rready_i) begin
      next_r.rvalid = 1'b0;
    end
    next_r.arready = ~next_r.rvalid;
  end

  // Readies come up one cycle after reset release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign awready_o = r.awready;
  assign wready_o  = r.wready;
  assign bvalid_o  = r.bvalid;
  assign bresp_o   = r.bresp;
  assign arready_o = r.arready;
  assign rvalid_o  = r.rvalid;
  assign rdata_o   = r.rdata;
  assign rresp_o   = r.rresp;
  assign wr_en_o   = commit & ce_i;
  assign wr_addr_o = r.awaddr;
  assign wr_data_o = r.wdata;
  assign wr_strb_o = r.wstrb;

endmodule
`default_nettype wire

/* logic/interrupt_enable_and_select.sv */
// Interrupt enable mask and source-select registers with request gating.
// Assumes synchronous level requests from the peripherals and AXI4-Lite access.
//
// Operation
// - A cleared global enable blocks every request towards the core.
// - With the global enable set each request passes only if its own enable is set.
// - The serial enable at bit 4 passes or suppresses the serial port request.
// - Bits 3 and 1 gate the timer 1 and timer 0 overflow requests.
// - Bit 2 of the enable register gates external input 1 requests.
// - Bit 0 of the enable register gates external input 0 requests.
// - Reset clears the global and all five source enables.
// - Card polarity cleared makes a low card presence level active, set makes high active.
// - The card detect flag is set by hardware and stays until software clears it.
// - Bit 2 of the select register enables the output-enable path into external input 1.
// - The card detect enable gates the card presence request.
// - Reset clears polarity, flag and enable bits of the select register.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_and_select #(
  parameter int ADDR_W = irq_sel_pkg::ADDR_W
) (
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            ce_i,
  input  wire logic [ADDR_W-1:0]               s_axil_awaddr_i,
  input  wire logic                            s_axil_awvalid_i,
  output logic                                 s_axil_awready_o,
  input  wire logic [31:0]                     s_axil_wdata_i,
  input  wire logic [3:0]                      s_axil_wstrb_i,
  input  wire logic                            s_axil_wvalid_i,
  output logic                                 s_axil_wready_o,
  output logic [1:0]                           s_axil_bresp_o,
  output logic                                 s_axil_bvalid_o,
  input  wire logic                            s_axil_bready_i,
  input  wire logic [ADDR_W-1:0]               s_axil_araddr_i,
  input  wire logic                            s_axil_arvalid_i,
  output logic                                 s_axil_arready_o,
  output logic [31:0]                          s_axil_rdata_o,
  output logic [1:0]                           s_axil_rresp_o,
  output logic                                 s_axil_rvalid_o,
  input  wire logic                            s_axil_rready_i,
  input  wire logic                            ext_irq_zero_pin_i,
  input  wire logic                            ext_irq_one_pin_i,
  input  wire logic                            timer0_overflow_i,
  input  wire logic                            timer1_overflow_i,
  input  wire logic                            serial_irq_i,
  input  wire logic                            card_presence_input_i,
  input  wire logic                            output_enable_input_i,
  input  wire logic                            rx_activity_i,
  output logic [irq_sel_pkg::NUM_SRC-1:0]      irq_req_o
);

  typedef struct packed {
    logic [7:0]                     ie;
    logic [7:0]                     sel;
    logic [irq_sel_pkg::NUM_SRC-1:0] irq;
  } ctl_state_t;

  ctl_state_t                       r;
  ctl_state_t                       next_r;

  logic                             wr_en;
  logic [ADDR_W-1:0]                wr_addr;
  logic [31:0]                      wr_data;
  logic [3:0]                       wr_strb;
  logic                             wr_lane0;
  logic                             wr_ie;
  logic                             wr_sel;
  logic                             wr_ok;
  logic [31:0]                      rd_data;
  logic                             rd_ok;
  logic                             card_flag;
  logic                             rx_flag;
  logic                             card_active;
  logic                             oe_active;
  logic                             card_clr;
  logic                             rx_clr;
  logic [irq_sel_pkg::NUM_SRC-1:0]  src_vec;
  logic [irq_sel_pkg::NUM_SRC-1:0]  en_vec;
  logic [7:0]                       sel_view;

  // Bus front end
  axil_reg_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .awaddr_i   (s_axil_awaddr_i),
    .awvalid_i  (s_axil_awvalid_i),
    .awready_o  (s_axil_awready_o),
    .wdata_i    (s_axil_wdata_i),
    .wstrb_i    (s_axil_wstrb_i),
    .wvalid_i   (s_axil_wvalid_i),
    .wready_o   (s_axil_wready_o),
    .bresp_o    (s_axil_bresp_o),
    .bvalid_o   (s_axil_bvalid_o),
    .bready_i   (s_axil_bready_i),
    .arvalid_i  (s_axil_arvalid_i),
    .arready_o  (s_axil_arready_o),
    .rdata_o    (s_axil_rdata_o),
    .rresp_o    (s_axil_rresp_o),
    .rvalid_o   (s_axil_rvalid_o),
    .rready_i   (s_axil_rready_i),
    .wr_en_o    (wr_en),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data),
    .wr_strb_o  (wr_strb),
    .wr_ok_i    (wr_ok),
    .rd_data_i  (rd_data),
    .rd_ok_i    (rd_ok)
  );

  // Write decode; only byte lane 0 carries register data
  assign wr_lane0 = wr_en & wr_strb[0];
  assign wr_ie    = wr_lane0 & irq_sel_pkg::hits(wr_addr, irq_sel_pkg::IE_ADDR);
  assign wr_sel   = wr_lane0 & irq_sel_pkg::hits(wr_addr, irq_sel_pkg::SEL_ADDR);
  assign wr_ok    = irq_sel_pkg::hits(wr_addr, irq_sel_pkg::IE_ADDR)
                  | irq_sel_pkg::hits(wr_addr, irq_sel_pkg::SEL_ADDR);

  // Writing zero to a flag clears it; writing one leaves it alone
  assign card_clr = wr_sel & ~wr_data[irq_sel_pkg::SEL_CD_FLAG];
  assign rx_clr   = wr_sel & ~wr_data[irq_sel_pkg::SEL_RX_FLAG];

  // Active level equals the polarity bit: zero means low is active
  assign card_active = card_presence_input_i == r.sel[irq_sel_pkg::SEL_CD_POL];
  assign oe_active   = output_enable_input_i == r.sel[irq_sel_pkg::SEL_OE_POL];

  // Card flag follows the active level, so it re-sets while the card stays
  event_flag u_card_flag (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .set_i      (card_active),
    .clr_i      (card_clr),
    .flag_o     (card_flag)
  );

  // Receive-line flag caught from activity pulses
  event_flag u_rx_flag (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .set_i      (rx_activity_i),
    .clr_i      (rx_clr),
    .flag_o     (rx_flag)
  );

  // Read view: unused bits read as zero, flags from their own flops
  always_comb begin
    sel_view = r.sel;
    sel_view[irq_sel_pkg::SEL_CD_FLAG] = card_flag;
    sel_view[irq_sel_pkg::SEL_RX_FLAG] = rx_flag;
  end

  // Read mux; an unmapped word answers zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b0;
    if (irq_sel_pkg::hits(s_axil_araddr_i, irq_sel_pkg::IE_ADDR)) begin
      rd_data[7:0] = r.ie;
      rd_ok        = 1'b1;
    end else if (irq_sel_pkg::hits(s_axil_araddr_i, irq_sel_pkg::SEL_ADDR)) begin
      rd_data[7:0] = sel_view;
      rd_ok        = 1'b1;
    end
  end

  // Raw requests; output-enable joins external input 1 only when allowed
  always_comb begin
    src_vec = '0;
    src_vec[irq_sel_pkg::SRC_EXT0]   = ext_irq_zero_pin_i;
    src_vec[irq_sel_pkg::SRC_TMR0]   = timer0_overflow_i;
    src_vec[irq_sel_pkg::SRC_EXT1]   = ext_irq_one_pin_i
                                     | (oe_active & r.sel[irq_sel_pkg::SEL_OE_EN]);
    src_vec[irq_sel_pkg::SRC_TMR1]   = timer1_overflow_i;
    src_vec[irq_sel_pkg::SRC_SERIAL] = serial_irq_i;
    src_vec[irq_sel_pkg::SRC_CARD]   = card_flag;
    src_vec[irq_sel_pkg::SRC_RX]     = rx_flag;
  end

  // Per-source enables
  always_comb begin
    en_vec = '0;
    en_vec[irq_sel_pkg::SRC_EXT0]   = r.ie[irq_sel_pkg::IE_X0];
    en_vec[irq_sel_pkg::SRC_TMR0]   = r.ie[irq_sel_pkg::IE_T0];
    en_vec[irq_sel_pkg::SRC_EXT1]   = r.ie[irq_sel_pkg::IE_X1];
    en_vec[irq_sel_pkg::SRC_TMR1]   = r.ie[irq_sel_pkg::IE_T1];
    en_vec[irq_sel_pkg::SRC_SERIAL] = r.ie[irq_sel_pkg::IE_SERIAL];
    en_vec[irq_sel_pkg::SRC_CARD]   = r.sel[irq_sel_pkg::SEL_CD_EN];
    en_vec[irq_sel_pkg::SRC_RX]     = r.sel[irq_sel_pkg::SEL_RX_EN];
  end

  // Register updates and the gated request vector
  always_comb begin
    next_r = r;
    // Unused bits never store, whatever software writes
    if (wr_ie) begin
      next_r.ie = wr_data[7:0] & irq_sel_pkg::IE_WMASK;
    end
    if (wr_sel) begin
      next_r.sel = wr_data[7:0] & irq_sel_pkg::SEL_WMASK;
    end
    // Global enable overrides every source enable
    if (r.ie[irq_sel_pkg::IE_GLOBAL]) begin
      next_r.irq = src_vec & en_vec;
    end else begin
      next_r.irq = '0;
    end
  end

  // State store, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.ie  <= irq_sel_pkg::IE_RESET;
      r.sel <= irq_sel_pkg::SEL_RESET;
      r.irq <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // Registered requests; one cycle behind the sources
  assign irq_req_o = r.irq;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_global_block;
    ce_i && !r.ie[irq_sel_pkg::IE_GLOBAL] |=> irq_req_o == '0;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("request passed with global enable clear");

  property p_forward_serial;
    ce_i && r.ie[irq_sel_pkg::IE_GLOBAL] && r.ie[irq_sel_pkg::IE_SERIAL] && serial_irq_i
      |=> irq_req_o[irq_sel_pkg::SRC_SERIAL];
  endproperty
  a_forward_serial: assert property (p_forward_serial)
    else $error("enabled serial request not forwarded");

  property p_serial_block;
    ce_i && !r.ie[irq_sel_pkg::IE_SERIAL] |=> !irq_req_o[irq_sel_pkg::SRC_SERIAL];
  endproperty
  a_serial_block: assert property (p_serial_block)
    else $error("serial request passed while disabled");

  property p_timer1_pass;
    ce_i && r.ie[irq_sel_pkg::IE_GLOBAL] && r.ie[irq_sel_pkg::IE_T1] && timer1_overflow_i
      |=> irq_req_o[irq_sel_pkg::SRC_TMR1];
  endproperty
  a_timer1_pass: assert property (p_timer1_pass)
    else $error("timer 1 overflow not forwarded");

  property p_timer0_block;
    ce_i && !r.ie[irq_sel_pkg::IE_T0] |=> !irq_req_o[irq_sel_pkg::SRC_TMR0];
  endproperty
  a_timer0_block: assert property (p_timer0_block)
    else $error("timer 0 overflow passed while disabled");

  property p_ext1_pass;
    ce_i && r.ie[irq_sel_pkg::IE_GLOBAL] && r.ie[irq_sel_pkg::IE_X1] && ext_irq_one_pin_i
      |=> irq_req_o[irq_sel_pkg::SRC_EXT1];
  endproperty
  a_ext1_pass: assert property (p_ext1_pass)
    else $error("external input 1 not forwarded");

  property p_ext0_block;
    ce_i && !r.ie[irq_sel_pkg::IE_X0] |=> !irq_req_o[irq_sel_pkg::SRC_EXT0];
  endproperty
  a_ext0_block: assert property (p_ext0_block)
    else $error("external input 0 passed while disabled");

  property p_reset_clear;
    $rose(rst_n_i) |-> r.ie == irq_sel_pkg::IE_RESET && irq_req_o == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("enable register not clear after reset");

  property p_card_level;
    ce_i && !r.sel[irq_sel_pkg::SEL_CD_POL] && !card_presence_input_i |=> card_flag;
  endproperty
  a_card_level: assert property (p_card_level)
    else $error("low card level did not set the flag");

  property p_card_sticky;
    ce_i && card_flag && !card_clr |=> card_flag;
  endproperty
  a_card_sticky: assert property (p_card_sticky)
    else $error("card flag dropped without a clear");

  property p_oe_path_off;
    ce_i && !r.sel[irq_sel_pkg::SEL_OE_EN] && !ext_irq_one_pin_i
      |=> !irq_req_o[irq_sel_pkg::SRC_EXT1];
  endproperty
  a_oe_path_off: assert property (p_oe_path_off)
    else $error("output-enable request passed while disabled");

  property p_card_block;
    ce_i && !r.sel[irq_sel_pkg::SEL_CD_EN] |=> !irq_req_o[irq_sel_pkg::SRC_CARD];
  endproperty
  a_card_block: assert property (p_card_block)
    else $error("card request passed while disabled");

  property p_sel_reset;
    $rose(rst_n_i) |-> r.sel == irq_sel_pkg::SEL_RESET && !rx_flag;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("select register not clear after reset");

  property p_rx_set;
    ce_i && rx_activity_i |=> rx_flag ##1 (rx_flag || !ce_i || $past(rx_clr));
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("receive-line flag not set or not held");

  property p_rx_block;
    ce_i && !r.sel[irq_sel_pkg::SEL_RX_EN] |=> !irq_req_o[irq_sel_pkg::SRC_RX];
  endproperty
  a_rx_block: assert property (p_rx_block)
    else $error("receive-line request passed while disabled");

  property p_oe_high;
    ce_i && r.ie[irq_sel_pkg::IE_GLOBAL] && r.ie[irq_sel_pkg::IE_X1]
      && r.sel[irq_sel_pkg::SEL_OE_EN] && r.sel[irq_sel_pkg::SEL_OE_POL]
      && output_enable_input_i |=> irq_req_o[irq_sel_pkg::SRC_EXT1];
  endproperty
  a_oe_high: assert property (p_oe_high)
    else $error("high output-enable level not forwarded");

  // Main scenarios reached
  c_card_irq: cover property (irq_req_o[irq_sel_pkg::SRC_CARD]);
  c_rx_irq: cover property (irq_req_o[irq_sel_pkg::SRC_RX]);
  c_blocked: cover property (!r.ie[irq_sel_pkg::IE_GLOBAL] && r.ie[irq_sel_pkg::IE_SERIAL]
                             && serial_irq_i);
  c_clear_race: cover property (card_clr && card_active);

endmodule
`default_nettype wire

/* tb/axil_master.sv */
// Core-side register access model: AXI4-Lite master, one transfer at a time.
// Assumes a slave on the same clock; the bench watchdog cuts any hang.
`timescale 1ns/10ps
`default_nettype none
module axil_master (
  input  wire logic        clk_i,
  output logic [11:0]      awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [11:0]      araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // Ready to take answers at all times, so no same-step toggling
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, araddr_o, arvalid_o} = '0;
    bready_o = 1'b1;
    rready_o = 1'b1;
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    awaddr_o  <= a;
    wdata_o   <= {24'h00_0000, d};
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_i);
      aw = aw | awready_i;
      w = w | wready_i;
      if (aw)
        awvalid_o <= 1'b0;
      if (w)
        wvalid_o <= 1'b0;
    end
    do
      @(posedge clk_i);
    while (!bvalid_i);
    r = bresp_i;
  endtask

  // Read: hold the address until taken, then wait for the data
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    do
      @(posedge clk_i);
    while (!arready_i);
    arvalid_o <= 1'b0;
    do
      @(posedge clk_i);
    while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
  endtask
endmodule
`default_nettype wire

/* tb/interrupt_enable_and_select_tb.sv */
// Self-checking bench for the interrupt enable and source-select block.
// Assumes the core-side master model drives the register bus.
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_and_select_tb;
  localparam logic [11:0] ENA = irq_sel_pkg::IE_ADDR;
  localparam logic [11:0] SEL = irq_sel_pkg::SEL_ADDR;
  localparam logic [1:0]  OKR = irq_sel_pkg::RESP_OKAY;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        x0 = 1'b0, x1 = 1'b0, t0 = 1'b0, t1 = 1'b0, ser = 1'b0;
  logic        cp = 1'b1, oe = 1'b0, rx = 1'b0, ce = 1'b1;
  logic [6:0]  irq;
  int          fail_count = 0;
  int          tests_run = 0;

  axil_master i_host (
    .clk_i(core_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready)
  );
  // Byte strobe held on: only full-byte writes are used
  interrupt_enable_and_select i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(4'h1), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
    .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
    .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
    .ext_irq_zero_pin_i(x0), .ext_irq_one_pin_i(x1), .timer0_overflow_i(t0),
    .timer1_overflow_i(t1), .serial_irq_i(ser), .card_presence_input_i(cp),
    .output_enable_input_i(oe), .rx_activity_i(rx), .irq_req_o(irq)
  );

  // 40 MHz core clock
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    note(got === exp, got, exp);
  endtask
  // Requests are registered; two edges covers the flag stage too
  task automatic cmp_irq(input logic [6:0] exp);
    repeat (2) @(posedge core_clk_i);
    #1;
    note(irq === exp, {25'h0, irq}, {25'h0, exp});
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host.wr(a, d, r);
    cmp_reg({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_host.rd(a, d, r);
    cmp_reg(d, {24'h00_0000, exp});
    cmp_reg({30'h0, r}, {30'h0, er});
  endtask

  task automatic t_reset;
    rd(ENA, 8'h00, OKR);
    rd(SEL, 8'h00, OKR);
    wr(12'h000, 8'h00, irq_sel_pkg::RESP_SLVERR);
    rd(12'h2a4, 8'h00, irq_sel_pkg::RESP_SLVERR);
  endtask
  // All five enable-register sources asserted: global gate first, then each enable alone
  task automatic t_gate;
    {x0, x1, t0, t1, ser} <= 5'h1f;
    wr(ENA, 8'h1f, OKR);
    cmp_irq(7'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ENA, 8'h80 | (8'h01 << i), OKR);
      cmp_irq(7'h01 << i);
    end
    wr(ENA, 8'h9f, OKR);
    cmp_irq(7'h1f);
    rd(ENA, 8'h9f, OKR);
    {x0, x1, t0, t1, ser} <= 5'h00;
  endtask
  // One-cycle low on the card input must leave a sticky flag
  task automatic t_card;
    wr(ENA, 8'h80, OKR);
    wr(SEL, 8'h02, OKR);
    cp <= 1'b0;
    @(posedge core_clk_i);
    cp <= 1'b1;
    cmp_irq(7'h20);
    rd(SEL, 8'h22, OKR);
    wr(SEL, 8'h02, OKR);
    cmp_irq(7'h00);
    wr(SEL, 8'h80, OKR);
    cmp_irq(7'h00);
    rd(SEL, 8'ha0, OKR);
    cp <= 1'b0;
    wr(SEL, 8'ha2, OKR);
    cmp_irq(7'h20);
    wr(SEL, 8'h82, OKR);
    rd(SEL, 8'h82, OKR);
    // Clear while the card level is active: the set must win
    wr(SEL, 8'h00, OKR);
    wr(SEL, 8'h80, OKR);
    rd(SEL, 8'ha0, OKR);
    wr(SEL, 8'h80, OKR);
  endtask
  // Polarity stays high so the low card input remains inactive
  task automatic t_rx;
    wr(SEL, 8'h81, OKR);
    // Clock enable low: the activity pulse must not be taken
    ce <= 1'b0;
    rx <= 1'b1;
    @(posedge core_clk_i);
    {ce, rx} <= 2'b10;
    cmp_irq(7'h00);
    rx <= 1'b1;
    @(posedge core_clk_i);
    rx <= 1'b0;
    cmp_irq(7'h40);
    wr(SEL, 8'h90, OKR);
    cmp_irq(7'h00);
    rd(SEL, 8'h90, OKR);
    wr(SEL, 8'h81, OKR);
    cmp_irq(7'h00);
  endtask
  task automatic t_oe;
    wr(ENA, 8'h84, OKR);
    oe <= 1'b1;
    wr(SEL, 8'h8c, OKR);
    cmp_irq(7'h04);
    oe <= 1'b0;
    cmp_irq(7'h00);
    wr(SEL, 8'h84, OKR);
    cmp_irq(7'h04);
    wr(SEL, 8'h80, OKR);
    cmp_irq(7'h00);
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_reset();
    t_gate();
    t_card();
    t_rx();
    t_oe();
    end_sim();
  end
  // Run needs well under 1000 cycles
  initial begin
    #100_000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
